/* File: mrom_consts.svh */
// timing and layout constants for the mask rom read controller
`ifndef MROM_CONSTS_SVH
`define MROM_CONSTS_SVH
`define MROM_CLK_NS 25
`define MROM_PWRUP_NS 200
`define MROM_PWRUP_CYC ((`MROM_PWRUP_NS + `MROM_CLK_NS - 1) / `MROM_CLK_NS)
`define MROM_ACC_NS 120
`define MROM_ACC_CYC ((`MROM_ACC_NS + `MROM_CLK_NS - 1) / `MROM_CLK_NS)
`define MROM_DF_NS 20
`define MROM_DF_CYC ((`MROM_DF_NS + `MROM_CLK_NS - 1) / `MROM_CLK_NS)
`define MROM_WADDR_W 23
`define MROM_BADDR_W 24
`define MROM_DATA_W 16
`define MROM_OPT_LOW 2'h0
`define MROM_OPT_HIGH 2'h1
`define MROM_OPT_IGN 2'h2
`endif

/* File: mrom_pkg.sv */
// types for the mask rom read controller
package mrom_pkg;
    typedef enum logic [1:0] {
        MROM_ST_PWRUP = 2'h0,
        MROM_ST_IDLE = 2'h1,
        MROM_ST_ACCESS = 2'h3,
        MROM_ST_RELEASE = 2'h2
    } mrom_state_e;
    typedef logic [1:0] mrom_opt_t;
endpackage : mrom_pkg

/* File: mrom_timer.sv */
// down counter that pulses done when a loaded count expires
`timescale 1ns/1ps
`default_nettype none
module mrom_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [3:0] count,
    output logic done
);
    logic [3:0] cnt_r;
    logic run_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            run_r <= 1'b0;
        end else if (load) begin
            cnt_r <= count;
            run_r <= 1'b1;
        end else if (run_r) begin
            if (cnt_r <= 4'h1) begin
                run_r <= 1'b0;
            end
            cnt_r <= cnt_r - 4'h1;
        end
    end

    assign done = run_r && (cnt_r <= 4'h1) && !load;
endmodule : mrom_timer
`default_nettype wire

/* File: mrom_host.sv */
// host controller reading an asynchronous mask rom
`timescale 1ns/1ps
`default_nettype none
`include "mrom_consts.svh"
module mrom_host
    import mrom_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] enable_option,
    input wire logic req_valid,
    input wire logic req_word,
    input wire logic [23:0] req_addr,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic [22:0] word_address,
    output logic chip_select_n,
    output logic output_enable,
    output logic width_select,
    output logic data_msb_out,
    output logic data_msb_oe,
    input wire logic [7:0] lower_data_bits,
    input wire logic [6:0] upper_data_bits,
    input wire logic data_msb_in
);
    // *****************************
    // input synchronisers
    // *****************************
    // rom data is sampled only after the access time has passed, yet the
    // pins are still foreign to clk, so three flops guard them
    logic [15:0] pin_s1_r;
    logic [15:0] pin_s2_r;
    logic [15:0] pin_s3_r;
    logic [15:0] pin_now;

    assign pin_now = {data_msb_in, upper_data_bits, lower_data_bits};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 16'h0000;
            pin_s2_r <= 16'h0000;
            pin_s3_r <= 16'h0000;
        end else begin
            pin_s1_r <= pin_now;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // *****************************
    // sequencing
    // *****************************
    mrom_state_e state_r;
    logic tmr_load;
    logic [3:0] tmr_count;
    logic tmr_done;
    logic [2:0] settle_r;
    logic word_r;
    logic take;

    // ready gate: a request seen while ready is still low is never taken
    assign take = (state_r == MROM_ST_IDLE) && req_ready && req_valid;

    mrom_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // power-up wait loaded straight out of reset; access time on a take;
    // disable time after release so the next host driver never fights the rom
    logic boot_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_r <= 1'b1;
        end else begin
            boot_r <= 1'b0;
        end
    end

    always_comb begin
        tmr_load = 1'b0;
        tmr_count = 4'h0;
        if (boot_r) begin
            tmr_load = 1'b1;
            tmr_count = 4'(`MROM_PWRUP_CYC);
        end else if (take) begin
            tmr_load = 1'b1;
            tmr_count = 4'(`MROM_ACC_CYC);
        end else if (state_r == MROM_ST_ACCESS && settle_r == 3'h3) begin
            tmr_load = 1'b1;
            tmr_count = 4'(`MROM_DF_CYC);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MROM_ST_PWRUP;
        end else begin
            unique case (state_r)
                MROM_ST_PWRUP: begin
                    if (tmr_done) begin
                        state_r <= MROM_ST_IDLE;
                    end
                end
                MROM_ST_IDLE: begin
                    if (take) begin
                        state_r <= MROM_ST_ACCESS;
                    end
                end
                MROM_ST_ACCESS: begin
                    if (settle_r == 3'h3) begin
                        state_r <= MROM_ST_RELEASE;
                    end
                end
                MROM_ST_RELEASE: begin
                    if (tmr_done) begin
                        state_r <= MROM_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // after the access time, wait three more edges so the synchronisers
    // carry the settled data before capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_r <= 3'h0;
        end else if (state_r != MROM_ST_ACCESS) begin
            settle_r <= 3'h0;
        end else if (settle_r != 3'h0 || tmr_done) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    // *****************************
    // pin drive
    // *****************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_select_n <= 1'b1;
        end else begin
            chip_select_n <= !(take || (state_r == MROM_ST_ACCESS && settle_r != 3'h3));
        end
    end

    // the enable level depends on the factory option of the fitted part
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_enable <= 1'b1;
        end else begin
            unique case (enable_option)
                `MROM_OPT_LOW: output_enable <= chip_select_n == 1'b1 && !take;
                `MROM_OPT_HIGH: output_enable <= take ||
                    (state_r == MROM_ST_ACCESS && settle_r != 3'h3);
                default: output_enable <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_address <= 23'h000000;
            width_select <= 1'b1;
            data_msb_out <= 1'b0;
            data_msb_oe <= 1'b0;
            word_r <= 1'b1;
        end else if (take) begin
            word_r <= req_word;
            width_select <= req_word;
            if (req_word) begin
                word_address <= req_addr[22:0];
                data_msb_oe <= 1'b0;
            end else begin
                word_address <= req_addr[23:1];
                data_msb_out <= req_addr[0];
                data_msb_oe <= 1'b1;
            end
        end
    end

    // *****************************
    // answer
    // *****************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= (state_r == MROM_ST_ACCESS) && settle_r == 3'h3;
            if (state_r == MROM_ST_ACCESS && settle_r == 3'h3) begin
                // upper byte is floating in byte mode, so it is masked
                rsp_data <= word_r ? pin_s3_r : {8'h00, pin_s3_r[7:0]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_r == MROM_ST_IDLE && !take) ||
                (state_r == MROM_ST_RELEASE && tmr_done);
        end
    end
endmodule : mrom_host
`default_nettype wire

/* File: mrom_host_props.sv */
// checker for the mask rom read controller ports
`timescale 1ns/1ps
`default_nettype none
module mrom_host_props
    import mrom_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] enable_option,
    input wire logic req_valid,
    input wire logic req_word,
    input wire logic [23:0] req_addr,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [22:0] word_address,
    input wire logic chip_select_n,
    input wire logic output_enable,
    input wire logic width_select,
    input wire logic data_msb_out,
    input wire logic data_msb_oe
);
    logic tw_r;
    logic [23:0] ta_r;
    logic [3:0] pw_r;
    wire logic take = req_valid && req_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pw_r <= 4'h0;
        end else if (pw_r != 4'hf) begin
            pw_r <= pw_r + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (take) begin
            tw_r <= req_word;
            ta_r <= req_addr;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pwrup; pw_r < 4'h8 |-> chip_select_n && !req_ready; endproperty
    a_pwrup: assert property (p_pwrup) else $error("select in wait");
    property p_take; take |=> !chip_select_n && !req_ready; endproperty
    a_take: assert property (p_take) else $error("no select");
    property p_pins; take |=> width_select == tw_r
        && word_address == (tw_r ? ta_r[22:0] : ta_r[23:1]); endproperty
    a_pins: assert property (p_pins) else $error("bad pins");
    property p_lsb; take && !req_word |=> data_msb_oe && data_msb_out == ta_r[0]; endproperty
    a_lsb: assert property (p_lsb) else $error("bad low address");
    property p_word; width_select && !chip_select_n |-> !data_msb_oe; endproperty
    a_word: assert property (p_word) else $error("msb driven");
    property p_pol; !chip_select_n |-> output_enable == (enable_option == 2'h1); endproperty
    a_pol: assert property (p_pol) else $error("bad enable");
    property p_ign; pw_r != 4'h0 && enable_option == 2'h2 |-> !output_enable; endproperty
    a_ign: assert property (p_ign) else $error("enable not low");
    property p_lat; take |-> ##[6:14] rsp_valid; endproperty
    a_lat: assert property (p_lat) else $error("no answer");
    property p_rel; rsp_valid |-> chip_select_n; endproperty
    a_rel: assert property (p_rel) else $error("select held");
    c_word: cover property (take && req_word);
    c_byte: cover property (take && !req_word);
    c_ign: cover property (rsp_valid && enable_option == 2'h2);
endmodule : mrom_host_props
bind mrom_host mrom_host_props mrom_host_props_i (.*);
`default_nettype wire

/* File: mrom_model.sv */
// behavioural model of the mask rom read pins
`timescale 1ns/1ps
`default_nettype none
`include "mrom_consts.svh"
module mrom_model (
    input wire logic clk,
    input wire logic [1:0] enable_option,
    input wire logic [22:0] word_address,
    input wire logic chip_select_n,
    input wire logic output_enable,
    input wire logic width_select,
    input wire logic data_msb_out,
    input wire logic data_msb_oe,
    output logic [7:0] lower_data_bits,
    output logic [6:0] upper_data_bits,
    output logic data_msb_in
);
    // floating pins toggle every cycle so a stale sample never matches
    logic t = 1'b0;
    logic [15:0] d;
    logic on;
    logic lsb;
    always @(posedge clk) t <= ~t;
    assign #100 d = word_address[15:0] ^ {word_address[22:15], 8'h5a};
    assign #20 on = !chip_select_n && (enable_option == 2'h2
        || output_enable == (enable_option == 2'h1));
    assign lsb = data_msb_oe ? data_msb_out : t;
    assign lower_data_bits = !on ? {8{t}} : (!width_select && lsb) ? d[15:8] : d[7:0];
    assign upper_data_bits = (on && width_select) ? d[14:8] : {7{t}};
    assign data_msb_in = data_msb_oe ? data_msb_out : (on && width_select) ? d[15] : t;
endmodule : mrom_model
`default_nettype wire

/* File: mrom_host_tb_top.sv */
// testbench for the mask rom read controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module mrom_host_tb_top;
    import mrom_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] enable_option = 2'h0;
    logic req_valid = 1'b0;
    logic req_word = 1'b0;
    logic [23:0] req_addr = 24'h0;
    logic req_ready, rsp_valid, width_select, chip_select_n, output_enable;
    logic data_msb_out, data_msb_oe, data_msb_in;
    logic [15:0] rsp_data;
    logic [22:0] word_address;
    logic [7:0] lower_data_bits;
    logic [6:0] upper_data_bits;
    int n_fail = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    mrom_host mrom_host_i (.*);
    mrom_model mrom_model_i (.*);
    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic wait_ready;
        int i;
        i = 0;
        do @(posedge clk); while (req_ready !== 1'b1 && ++i < 40);
        `CHK(req_ready, 1'b1)
    endtask : wait_ready
    task automatic rd(input logic w, input logic [23:0] a);
        logic [22:0] wa;
        logic [15:0] d;
        int i;
        wa = w ? a[22:0] : a[23:1];
        d = wa[15:0] ^ {wa[22:15], 8'h5a};
        wait_ready;
        req_valid <= 1'b1;
        req_word <= w;
        req_addr <= a;
        @(posedge clk);
        req_valid <= 1'b0;
        i = 0;
        do @(posedge clk); while (rsp_valid !== 1'b1 && ++i < 30);
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_data, w ? d : {8'h00, a[0] ? d[15:8] : d[7:0]})
        @(posedge clk);
        `CHK(rsp_valid, 1'b0)
    endtask : rd
    task automatic t_pwrup;
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 40) begin
            @(posedge clk);
            `CHK(chip_select_n, 1'b1)
            i++;
        end
        `CHK(i >= 8, 1'b1)
        `CHK(req_ready, 1'b1)
    endtask : t_pwrup
    task automatic t_opts;
        for (int o = 0; o < 3; o++) begin
            enable_option <= o[1:0];
            rd(1'b1, 24'h7fffff);
            rd(1'b0, 24'hffffff);
            rd(1'b0, 24'h000002);
        end
    endtask : t_opts
    task automatic t_rst;
        wait_ready;
        req_valid <= 1'b1;
        req_word <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        `CHK(chip_select_n, 1'b1)
        rst_n <= 1'b1;
        // a request held through the wait must not be taken early
        req_valid <= 1'b1;
        t_pwrup;
        req_valid <= 1'b0;
        rd(1'b1, 24'h000000);
    endtask : t_rst
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_pwrup;
        t_opts;
        t_rst;
        close_out;
    end
    // whole run is under two hundred cycles, so this only trips on a hang
    initial begin
        #100000;
        n_fail++;
        close_out;
    end
endmodule : mrom_host_tb_top
`default_nettype wire
